/* File: pkg/csc_defines.vh */
// Constants for the clocked serial channel: register indices, field
// positions and reset values.
// Assumes inclusion by bare name from the design file and the checker.
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

// Register indices; byte address is four times the index
`define CSC_IDX_MODE      16'hFF60
`define CSC_IDX_BUSCTL    16'hFF61
`define CSC_IDX_SHIFT     16'hFF68
`define CSC_IDX_SLVADDR   16'hFF69
`define CSC_IDX_STATUS    16'hFF6A
`define CSC_IDX_CLKCFG    16'hFF6B

// Mode register fields
`define CSC_MODE_EN       7
`define CSC_MODE_MATCH    6
`define CSC_MODE_WAKE     5
`define CSC_MODE_SELHI    4
`define CSC_MODE_SELLO    3
`define CSC_MODE_ORDER    2
`define CSC_MODE_CLKHI    1
`define CSC_MODE_CLKLO    0

// Bus control register fields
`define CSC_BUS_RELEASE_TRIGGER      0
`define CSC_BUS_COMMAND_TRIGGER      1

// Status register fields
`define CSC_ST_DONE       0
`define CSC_ST_BUSY       1
`define CSC_ST_SCKLVL     2

// Clock configuration register fields
`define CSC_CFG_PORTLAT   4

// Reset values and last bit count
`define CSC_RST_BYTE      8'h00
`define CSC_RST_SHIFT     8'hFF
`define CSC_RST_PRE       4'h0
`define CSC_LAST_BIT      3'h7

`endif

/* File: src/csc_channel.v */
// Clocked serial channel: 3-wire and 2-wire byte shifter behind an
// Avalon-MM slave with waitrequest.
// Assumes serial pins arrive asynchronously; timer tick is on clk_i.
// Limitation: with an external clock, a shift write while the synced clock pin reads low starts nothing
//
// Contract
// - Release trigger sets output latch, reads zero
// - Command trigger clears output latch, reads zero
// - 3-wire exchanges whole bytes, bit per clock
// - Shift on falling edge; output from latch
// - Serial input captured on rising edge
// - After eight bits stop, set done flag
// - Serial output pin always shows output latch
// - Internal clock pin idles at port latch
// - Mode bit 2 selects MSB or LSB first
// - Bit order reverses bus mapping, not shifting
// - Write starts transfer when enabled and idle
// - Enabling after write starts no transfer
// - Clock source: external, timer, or prescaler
// - 2-wire uses clock plus selected open-drain line
// - Match flag compares address and shift data
// - Enable gates transfers, triggers, match and clock/line drive; reset clears mode
`timescale 1ns/1ns
`include "csc_defines.vh"

module csc_channel #(
   parameter PRE_W = 4
) (
   input  wire        clk_i,
   input  wire        arst_n_i,
   input  wire [17:0] avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   input  wire        timer_two_i,
   input  wire        serial_in_i,
   output reg         serial_out_o,
   input  wire        serial_clock_pin_i,
   output reg         serial_clock_pin_o,
   output reg         serial_clock_pin_oe_n_o,
   input  wire        bus_data_line_a_i,
   output reg         bus_data_line_a_o,
   output reg         bus_data_line_a_oe_n_o,
   input  wire        bus_data_line_b_i,
   output reg         bus_data_line_b_o,
   output reg         bus_data_line_b_oe_n_o,
   output reg         transfer_done_flag_o
);

   // Mirror a byte; used on both the write and the read path
   function [7:0] csc_rev8;
      input [7:0] v;
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            csc_rev8[k] = v[7-k];
         end
      end
   endfunction

   // Register select, shared by every write strobe
   function csc_hit;
      input [15:0] a;
      input [15:0] r;
      begin
         csc_hit = (a == r);
      end
   endfunction

   // Registers, flags and shifter state
   reg  [7:0]       mode_q;
   reg  [7:0]       busctl_q;
   reg  [7:0]       shift_q;
   reg  [7:0]       slvaddr_q;
   reg  [PRE_W-1:0] pre_sel_q;
   reg              port_latch_q;
   reg              done_q;
   reg              busy_q;
   reg              so_latch_q;
   reg  [2:0]       bit_cnt_q;
   reg              int_sck_q;
   reg  [PRE_W:0]   pre_cnt_q;
   // Pin synchroniser stages and timer edge history
   reg  [2:0]       sck_sync_q;
   reg  [1:0]       si_sync_q;
   reg  [1:0]       sba_sync_q;
   reg  [1:0]       sbb_sync_q;
   reg  [1:0]       tmr_q;

   // Mode register fields
   wire        enable   = mode_q[`CSC_MODE_EN];
   wire        two_wire = mode_q[`CSC_MODE_SELHI];
   wire        use_a    = mode_q[`CSC_MODE_SELLO];
   wire        lsb_first = mode_q[`CSC_MODE_ORDER];
   wire        internal = mode_q[`CSC_MODE_CLKHI];
   wire        use_pre  = mode_q[`CSC_MODE_CLKLO];
   // Bus side: index, accepted access, written byte
   wire [15:0] idx      = avs_address_i[17:2];
   wire        acc      = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   wire        wr_lane  = avs_write_i & acc & avs_byteenable_i[0];
   wire [7:0]  wbyte    = avs_writedata_i[7:0];
   wire        sck_lvl  = sck_sync_q[1];
   wire        match    = enable & (slvaddr_q == shift_q);

   // Decoded write strobes
   wire        wr_shift  = wr_lane & csc_hit(idx, `CSC_IDX_SHIFT);
   wire        wr_busctl = wr_lane & csc_hit(idx, `CSC_IDX_BUSCTL);
   wire        wr_status = wr_lane & csc_hit(idx, `CSC_IDX_STATUS);
   // Trigger writes; release wins when both bits are set
   wire        trig_rel  = wr_busctl & wbyte[`CSC_BUS_RELEASE_TRIGGER];
   wire        trig_cmd  = wr_busctl & wbyte[`CSC_BUS_COMMAND_TRIGGER];
   // Prescaler select widened for the read path
   wire [PRE_W+3:0] pre_ext = {4'h0, pre_sel_q};

   // Source of serial data input: pin or selected bus line
   wire        rx_bit   = two_wire ? (use_a ? sba_sync_q[1] : sbb_sync_q[1])
                                   : si_sync_q[1];

   // Timer tick: edge of timer output, same clock domain
   wire        tmr_tick = tmr_q[0] & ~tmr_q[1];
   wire        pre_tick = (pre_cnt_q[PRE_W-1:0] == pre_sel_q);
   wire        int_tick = use_pre ? pre_tick : tmr_tick;

   // Serial clock edges seen by the shifter
   // External edges land two to three cycles after the pin
   wire ext_fall = sck_sync_q[2] & ~sck_sync_q[1];
   wire ext_rise = ~sck_sync_q[2] & sck_sync_q[1];
   wire int_fall = busy_q & int_tick & int_sck_q;
   wire int_rise = busy_q & int_tick & ~int_sck_q;
   wire sck_fall = busy_q & (internal ? int_fall : ext_fall);
   wire sck_rise = busy_q & (internal ? int_rise : ext_rise);

   // Start needs enable and an idle clock; later enabling does nothing
   wire start = wr_shift & enable & ~busy_q
                & (internal | sck_lvl);
   // Eighth rising edge ends the byte
   wire last  = sck_rise & (bit_cnt_q == `CSC_LAST_BIT);

   // Bus handshake: waitrequest drops one cycle after a request
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         // Low one cycle only, so each access takes two cycles
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i)
                                & avs_waitrequest_o);
      end
   end

   // Read data captured while waitrequest is still high
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (avs_read_i & avs_waitrequest_o) begin
         // Unmapped indices read as zero
         case (idx)
            // Match is read live, never stored
            `CSC_IDX_MODE:
               avs_readdata_o <= {24'h000000, enable, match,
                                  mode_q[5:0]};
            `CSC_IDX_BUSCTL:
               avs_readdata_o <= {24'h000000, busctl_q[7:2],
                                  2'b00};
            `CSC_IDX_SHIFT:
               avs_readdata_o <= {24'h000000, lsb_first ?
                                  csc_rev8(shift_q) : shift_q};
            `CSC_IDX_SLVADDR:
               avs_readdata_o <= {24'h000000, slvaddr_q};
            // Clock level reads zero while disabled
            `CSC_IDX_STATUS:
               avs_readdata_o <= {29'h00000000, enable & sck_lvl,
                                  busy_q, done_q};
            `CSC_IDX_CLKCFG:
               avs_readdata_o <= {27'h0000000, port_latch_q,
                                  pre_ext[3:0]};
            default:
               avs_readdata_o <= 32'h00000000;
         endcase
      end
   end

   // Control registers; reset clears mode and bus control
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // Port latch resets high, as does the idle clock
         mode_q       <= `CSC_RST_BYTE;
         busctl_q     <= `CSC_RST_BYTE;
         slvaddr_q    <= `CSC_RST_BYTE;
         pre_sel_q    <= {PRE_W{1'b0}};
         port_latch_q <= 1'b1;
      end else if (wr_lane) begin
         case (idx)
            `CSC_IDX_MODE: begin
               mode_q <= {wbyte[7], 1'b0, wbyte[5:0]};
            end
            `CSC_IDX_BUSCTL: begin
               // Trigger bits act in the shifter, never stored
               busctl_q <= {wbyte[7:2], 2'b00};
            end
            `CSC_IDX_SLVADDR: begin
               slvaddr_q <= wbyte;
            end
            `CSC_IDX_CLKCFG: begin
               // Port latch sets the idle clock pin level
               pre_sel_q    <= wbyte[PRE_W-1:0];
               port_latch_q <= wbyte[`CSC_CFG_PORTLAT];
            end
            default: begin
               mode_q <= mode_q;
            end
         endcase
      end
   end

   // Pin synchronisers; the second stage feeds logic, and the clock pin's third stage too
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // Idle levels, so no false edge after reset
         sck_sync_q <= 3'h7;
         si_sync_q  <= 2'h3;
         sba_sync_q <= 2'h3;
         sbb_sync_q <= 2'h3;
         tmr_q      <= 2'h0;
      end else begin
         // Clock pin has a third stage for edge detection
         sck_sync_q <= {sck_sync_q[1:0], serial_clock_pin_i};
         si_sync_q  <= {si_sync_q[0], serial_in_i};
         sba_sync_q <= {sba_sync_q[0], bus_data_line_a_i};
         sbb_sync_q <= {sbb_sync_q[0], bus_data_line_b_i};
         tmr_q      <= {tmr_q[0], timer_two_i};
      end
   end

   // Prescaler: one tick every pre_sel+1 cycles while shifting
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pre_cnt_q <= {(PRE_W+1){1'b0}};
      end else if (!busy_q || pre_tick) begin
         // Held at zero while idle, so every byte starts alike
         pre_cnt_q <= {(PRE_W+1){1'b0}};
      end else begin
         pre_cnt_q <= pre_cnt_q + {{PRE_W{1'b0}}, 1'b1};
      end
   end

   // Internal serial clock idles high, toggles on each tick
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         int_sck_q <= 1'b1;
      end else if (!busy_q) begin
         int_sck_q <= 1'b1;
      end else if (internal && int_tick) begin
         // Only a tick moves it, so with the prescaler the first half period is whole
         int_sck_q <= ~int_sck_q;
      end
   end

   // Shifter: out on falling edge, in on rising edge
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // All ones, so a receive releases an open-drain line
         shift_q    <= `CSC_RST_SHIFT;
         so_latch_q <= 1'b1;
         bit_cnt_q  <= 3'h0;
         busy_q     <= 1'b0;
      end else if (!enable) begin
         busy_q    <= 1'b0;
         bit_cnt_q <= 3'h0;
         // Stop mode: a write just stores the byte
         if (wr_shift) begin
            shift_q <= lsb_first ? csc_rev8(wbyte) : wbyte;
         end
      end else if (start) begin
         // Latch keeps its level until the first falling edge
         shift_q   <= lsb_first ? csc_rev8(wbyte) : wbyte;
         busy_q    <= 1'b1;
         bit_cnt_q <= 3'h0;
      end else if (busy_q) begin
         // Triggers are ignored here so a byte cannot be upset
         if (sck_fall) begin
            so_latch_q <= shift_q[7];
         end
         if (sck_rise) begin
            shift_q   <= {shift_q[6:0], rx_bit};
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
         if (last) begin
            busy_q <= 1'b0;
         end
      end else if (trig_rel) begin
         // Release wins when both trigger bits are written
         so_latch_q <= 1'b1;
      end else if (trig_cmd) begin
         so_latch_q <= 1'b0;
      end
   end

   // Done flag: end of byte wins over a clear in the same cycle
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_q <= 1'b0;
      end else if (last) begin
         done_q <= 1'b1;
      end else if (wr_status && wbyte[`CSC_ST_DONE]) begin
         // Cleared by writing one to the status done bit
         done_q <= 1'b0;
      end
   end

   // Pin drivers, all registered; open-drain lines pull low only
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         serial_out_o            <= 1'b1;
         serial_clock_pin_o      <= 1'b1;
         serial_clock_pin_oe_n_o <= 1'b1;
         bus_data_line_a_o       <= 1'b0;
         bus_data_line_a_oe_n_o  <= 1'b1;
         bus_data_line_b_o       <= 1'b0;
         bus_data_line_b_oe_n_o  <= 1'b1;
         transfer_done_flag_o    <= 1'b0;
      end else begin
         // Data pin follows the latch in every mode
         serial_out_o <= so_latch_q;
         // Idle level follows the port latch, shifting uses int clock
         serial_clock_pin_o <= busy_q ? int_sck_q : port_latch_q;
         // Clock pin driven only when enabled with an internal source
         serial_clock_pin_oe_n_o <= ~(enable & internal);
         // Open-drain lines never drive high
         bus_data_line_a_o <= 1'b0;
         bus_data_line_b_o <= 1'b0;
         // Released line reads the bus, so receive needs 0xFF loaded
         bus_data_line_a_oe_n_o <= ~(enable & two_wire & use_a
                                     & ~so_latch_q);
         bus_data_line_b_oe_n_o <= ~(enable & two_wire & ~use_a
                                     & ~so_latch_q);
         // Done pin mirrors the flag one cycle later
         transfer_done_flag_o <= done_q;
      end
   end

endmodule

/* File: tb/csc_checker.sv */
// Port-level checks for the serial channel: bus handshake, lines, shift
// Assumes binding onto csc_channel, one clock, reset active low
`timescale 1ns/1ns
`include "csc_defines.vh"
module csc_checker (
   input wire        clk_i,
   input wire        arst_n_i,
   input wire [17:0] avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire        avs_waitrequest_o,
   input wire        serial_out_o,
   input wire        serial_clock_pin_o,
   input wire        serial_clock_pin_oe_n_o,
   input wire        bus_data_line_a_o,
   input wire        bus_data_line_a_oe_n_o,
   input wire        bus_data_line_b_o,
   input wire        bus_data_line_b_oe_n_o,
   input wire        transfer_done_flag_o
);
   logic [3:0] rise_q;
   wire        take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Clock rises since the last shift write, judged when done rises
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         rise_q <= 4'h0;
      else if (take && avs_write_i
               && avs_address_i[17:2] == `CSC_IDX_SHIFT)
         rise_q <= 4'h0;
      else if (!serial_clock_pin_oe_n_o && $rose(serial_clock_pin_o))
         rise_q <= rise_q + 4'h1;
   end
   a_wait_answer: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
      else $error("bus request not answered in one cycle");
   a_wait_single: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_wait_cause: assert property (
      !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
      else $error("waitrequest low without a request");
   a_lines_low: assert property (
      !bus_data_line_a_o && !bus_data_line_b_o)
      else $error("open-drain line drives high");
   a_lines_one: assert property (
      bus_data_line_a_oe_n_o || bus_data_line_b_oe_n_o)
      else $error("both data lines pulled at once");
   a_line_follows: assert property (
      !bus_data_line_a_oe_n_o || !bus_data_line_b_oe_n_o
      |-> !serial_out_o)
      else $error("data line pulled while latch is high");
   a_out_moves: assert property (
      $changed(serial_out_o) && !serial_clock_pin_oe_n_o
      |-> !serial_clock_pin_o || $past(take, 1) || $past(take, 2))
      else $error("serial output moved while clock high");
   a_eight_rises: assert property (
      $rose(transfer_done_flag_o) && !serial_clock_pin_oe_n_o
      |-> ##[0:2] rise_q == 4'h8)
      else $error("done without exactly eight clock rises");
endmodule
bind csc_channel csc_checker chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .serial_out_o(serial_out_o), .serial_clock_pin_o(serial_clock_pin_o),
   .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o),
   .bus_data_line_a_o(bus_data_line_a_o),
   .bus_data_line_a_oe_n_o(bus_data_line_a_oe_n_o),
   .bus_data_line_b_o(bus_data_line_b_o),
   .bus_data_line_b_oe_n_o(bus_data_line_b_oe_n_o),
   .transfer_done_flag_o(transfer_done_flag_o));

/* File: tb/csc_peer.sv */
// Far-side serial peer: sends a byte MSB first, collects device data
// Assumes the clock idles high and a load pulse comes between frames
`timescale 1ns/1ns
module csc_peer (
   input  wire logic       sck_i,
   input  wire logic       sdo_i,
   input  wire logic       load_i,
   input  wire logic [7:0] tx_i,
   output logic            sdi_o,
   output logic [7:0]      rx_o
);
   logic [7:0] tx_q = 8'h00;
   initial sdi_o = 1'b1;
   initial rx_o = 8'h00;
   always @(posedge load_i)
      tx_q <= tx_i;
   // New bit on the falling edge; the fill pattern keeps stale data moving
   always @(negedge sck_i) begin
      sdi_o <= tx_q[7];
      tx_q <= {tx_q[6:0], ~tx_q[7]};
   end
   // Capture where the device holds its output steady
   always @(posedge sck_i)
      rx_o <= {rx_o[6:0], sdo_i};
endmodule

/* File: tb/test_clocked_serial_channel_3wire_2wire.sv */
// Self-checking bench for the serial channel: registers and transfers
// Assumes the peer model and the bound checker are compiled first
`timescale 1ns/1ns
module test_clocked_serial_channel_3wire_2wire;
   logic        clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic [17:0] adr = 18'h00000;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic        wait_o, sdo, sdi, sck_o, sck_oe_n, done;
   logic        tmr = 1'b0, ext = 1'b1, load = 1'b0;
   logic        a_o, a_oe_n, b_o, b_oe_n;
   logic [7:0]  ptx = 8'h00;
   logic [7:0]  prx, v;
   logic [2:0]  tcnt = 3'h0;
   int          error_cnt = 0;
   int          checks = 0;
   wire         sck = sck_oe_n ? ext : sck_o;
   always #5 clk_i = ~clk_i;
   // Slow timer tick so each half period clears the pin synchronisers
   always @(posedge clk_i) begin
      tcnt <= tcnt + 3'h1;
      tmr <= tcnt[2];
   end
   // Data lines have pull-ups; only the device pulls them low
   csc_channel dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
      .timer_two_i(tmr), .serial_in_i(sdi), .serial_out_o(sdo),
      .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe_n_o(sck_oe_n), .bus_data_line_a_i(a_oe_n),
      .bus_data_line_a_o(a_o), .bus_data_line_a_oe_n_o(a_oe_n),
      .bus_data_line_b_i(b_oe_n), .bus_data_line_b_o(b_o),
      .bus_data_line_b_oe_n_o(b_oe_n), .transfer_done_flag_o(done));
   csc_peer peer_u (.sck_i(sck), .sdo_i(sdo), .load_i(load),
      .tx_i(ptx), .sdi_o(sdi), .rx_o(prx));
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Request held until waitrequest is sampled low at an edge
   task automatic bus(input logic w, input logic [15:0] i,
                      input logic [7:0] d);
      int n = 0;
      adr <= {i, 2'b00};
      wdat <= {24'h000000, d};
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_o !== 1'b0 && n < 100);
      v = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
      if (n >= 100) begin
         error_cnt++;
         print_verdict;
      end
   endtask
   task automatic rd8(input logic [15:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk(v, e);
      chk(8'(|rdat[31:8]), 8'h00);
   endtask
   function automatic logic [7:0] rev(input logic [7:0] d);
      for (int k = 0; k < 8; k++)
         rev[k] = d[7 - k];
   endfunction
   task automatic t_reset;
      rd8(16'hFF60, 8'h00);
      rd8(16'hFF61, 8'h00);
      rd8(16'hFF68, 8'hFF);
      rd8(16'hFF69, 8'h00);
      rd8(16'hFF6B, 8'h10);
      rd8(16'hFF70, 8'h00);
      chk(8'(sdo), 8'h01);
   endtask
   // Triggers only while idle, so the latch is never moved mid-byte
   task automatic t_trig;
      bus(1'b1, 16'hFF6B, 8'h14);
      bus(1'b1, 16'hFF61, 8'h03);
      rd8(16'hFF61, 8'h00);
      bus(1'b1, 16'hFF60, 8'h83);
      bus(1'b1, 16'hFF6B, 8'h04);
      cyc(2);
      chk({7'h00, sck_o}, 8'h00);
      bus(1'b1, 16'hFF6B, 8'h14);
      cyc(2);
      chk({7'h00, sck_o}, 8'h01);
      bus(1'b1, 16'hFF61, 8'hFE);
      cyc(2);
      chk(8'(sdo), 8'h00);
      rd8(16'hFF61, 8'hFC);
      bus(1'b1, 16'hFF61, 8'h01);
      cyc(2);
      chk(8'(sdo), 8'h01);
      rd8(16'hFF61, 8'h00);
   endtask
   task automatic t_late_enable;
      bus(1'b1, 16'hFF60, 8'h03);
      bus(1'b1, 16'hFF68, 8'h5A);
      bus(1'b1, 16'hFF60, 8'h83);
      cyc(60);
      rd8(16'hFF6A, 8'h04);
      rd8(16'hFF68, 8'h5A);
   endtask
   // Mode, order included, is set before the data is written
   task automatic t_xfer(input logic [7:0] m, input logic [7:0] d,
                         input logic [7:0] p);
      ptx <= p;
      load <= 1'b1;
      bus(1'b1, 16'hFF60, m);
      bus(1'b1, 16'hFF69, p);
      bus(1'b1, 16'hFF68, d);
      load <= 1'b0;
      if (!m[1])
         repeat (8) begin
            ext <= 1'b0;
            cyc(6);
            ext <= 1'b1;
            cyc(6);
         end
      for (int n = 0; n < 2000 && done !== 1'b1; n++)
         @(posedge clk_i);
      if (done !== 1'b1) begin
         error_cnt++;
         print_verdict;
      end
      cyc(20);
      chk(8'(done), 8'h01);
      chk(prx, m[2] ? rev(d) : d);
      rd8(16'hFF68, m[2] ? rev(p) : p);
      rd8(16'hFF6A, 8'h05);
      if (!m[2])
         rd8(16'hFF60, m | 8'h40);
      bus(1'b1, 16'hFF6A, 8'h01);
      cyc(2);
      chk(8'(done), 8'h00);
   endtask
   // Two-wire modes: a command trigger pulls the selected line, release frees both
   task automatic t_two;
      bus(1'b1, 16'hFF60, 8'h9B);
      bus(1'b1, 16'hFF61, 8'h02);
      cyc(2);
      chk({6'h00, a_oe_n, b_oe_n}, 8'h01);
      bus(1'b1, 16'hFF60, 8'h93);
      cyc(2);
      chk({6'h00, a_oe_n, b_oe_n}, 8'h02);
      bus(1'b1, 16'hFF61, 8'h01);
      cyc(2);
      chk({6'h00, a_oe_n, b_oe_n}, 8'h03);
      bus(1'b1, 16'hFF60, 8'h03);
      rd8(16'hFF60, 8'h03);
   endtask
   initial begin
      cyc(10);
      arst_n_i <= 1'b1;
      cyc(1);
      t_reset;
      t_trig;
      t_late_enable;
      t_xfer(8'h83, 8'hA5, 8'h3C);
      t_xfer(8'h87, 8'h81, 8'hC6);
      t_xfer(8'h82, 8'h12, 8'h7E);
      t_xfer(8'h80, 8'hF0, 8'h96);
      t_two;
      print_verdict;
   end
endmodule
